// ### rtl/mci_ctrl.sv
// Interrupt arbitration, pending flags and vector supply for the main processor
//
// The implementer's own choices: the register offsets and strobed register access.
`timescale 1ns/1ps
module mci_ctrl (
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire mci_pkg::mci_bus_req_t bus,
  output logic [mci_pkg::DATA_W-1:0] reg_rdata,
  input  wire mci_pkg::mci_events_t  events,
  input  wire logic                  vblank_start,
  input  wire logic                  port_g_bit_zero,
  input  wire logic                  port_g_bit_zero_is_input,
  input  wire logic                  cpu_mask_flag,
  input  wire logic                  cpu_ack,
  input  wire logic                  cpu_done,
  output logic                       cpu_irq,
  output logic                       cpu_nmi,
  output logic [23:0]                vector_addr,
  output logic                       vector_valid,
  output logic                       irq_out
);
  import mci_pkg::*;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------

  // Index of the highest priority set bit among the maskable lines.
  // Priority follows the bit order: sync serial outranks clock/position.
  function automatic logic [2:0] pick_winner(input logic [NUM_MASKABLE-1:0] req);
    logic [2:0] idx;
    idx = 3'h7;                                        // Nothing requested
    if (req[SRC_PIN])              idx = 3'(SRC_PIN);
    else if (req[SRC_PERIODIC])    idx = 3'(SRC_PERIODIC);
    else if (req[SRC_SOUND])       idx = 3'(SRC_SOUND);
    else if (req[SRC_SERIAL])      idx = 3'(SRC_SERIAL);
    else if (req[SRC_SYNC_SERIAL]) idx = 3'(SRC_SYNC_SERIAL);
    else if (req[SRC_CLOCK_POS])   idx = 3'(SRC_CLOCK_POS);
    return idx;
  endfunction : pick_winner

  // Vector address for a source index, bank byte forced to zero
  function automatic logic [23:0] vector_of(input logic [2:0] idx);
    logic [23:0] v;
    case (idx)
      3'(SRC_PIN):         v = VEC_PIN;
      3'(SRC_PERIODIC):    v = VEC_PERIODIC;
      3'(SRC_SOUND):       v = VEC_SOUND;
      3'(SRC_SERIAL):      v = VEC_SERIAL;
      3'(SRC_SYNC_SERIAL): v = VEC_SYNC_SERIAL;
      3'(SRC_CLOCK_POS):   v = VEC_CLOCK_POS;
      default:             v = VEC_BLANK;
    endcase
    return {BANK_ZERO, v[15:0]};
  endfunction : vector_of

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [DATA_W-1:0]      display_control_one;         // Bit zero enables blanking request
  logic [DATA_W-1:0]      pin_edge_control;            // Bit zero arms pin detection
  logic [NUM_SOURCES-1:0] pending;                     // Sticky per-source flags
  logic [DATA_W-1:0]      pending_mask;                // Line enables, same layout
  logic                   nmi_pending;                 // Blanking request awaiting acceptance
  mci_state_t             state;                       // Service state
  mci_state_t             next_state;                  // Next service state
  logic [2:0]             served;                      // Source being served, 7 for none
  logic                   pin_fall;                    // Synchronised falling edge pulse

  wire                    blanking_request_enable;     // Decoded enable
  wire                    pin_edge_request_enable;     // Decoded enable
  wire [NUM_SOURCES-1:0]  new_events;                  // Events arriving this cycle
  wire [NUM_SOURCES-1:0]  clear_bits;                  // Software write-one-to-clear
  wire [NUM_SOURCES-1:0]  next_pending;                // Pending after set and clear
  wire [NUM_MASKABLE-1:0] unmasked;                    // Pending and enabled maskable flags
  wire [2:0]              winner;                      // Current priority winner
  wire                    any_unmasked;                // Any enabled flag set
  wire                    take_nmi;                    // Acknowledge goes to blanking
  wire                    take_irq;                    // Acknowledge goes to maskable
  wire                    wr_display;                  // Write strobes per register
  wire                    wr_pin_edge;
  wire                    wr_status;
  wire                    wr_mask;
  logic [DATA_W-1:0]      rd_mux;                      // Combinational read value

  // ----------------------------------------------------------------
  // Pin edge detection
  // ----------------------------------------------------------------
  // The pin goes through two flops before the edge is judged
  mci_pin_edge u_pin_edge (
    .clk     (clk),
    .sys_rst (sys_rst),
    .pin     (port_g_bit_zero),
    .fall    (pin_fall)
  );

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  assign blanking_request_enable = display_control_one[BIT_BLANK_EN];
  assign pin_edge_request_enable = pin_edge_control[BIT_PIN_EDGE_EN];

  assign wr_display  = bus.wr && (bus.addr == OFS_DISPLAY_CONTROL_ONE);
  assign wr_pin_edge = bus.wr && (bus.addr == OFS_PIN_EDGE_CONTROL);
  assign wr_status   = bus.wr && (bus.addr == OFS_PENDING_STATUS);
  assign wr_mask     = bus.wr && (bus.addr == OFS_PENDING_MASK);

  // Event vector in source order; two sources share one line
  assign new_events[SRC_PIN]         = pin_fall && pin_edge_request_enable
                                       && port_g_bit_zero_is_input;
  assign new_events[SRC_PERIODIC]    = events.periodic;
  assign new_events[SRC_SOUND]       = events.sound;
  assign new_events[SRC_SERIAL]      = events.serial;
  assign new_events[SRC_SYNC_SERIAL] = events.sync_serial;
  assign new_events[SRC_CLOCK_POS]   = events.clock_pos;
  assign new_events[SRC_BLANK]       = vblank_start && blanking_request_enable;

  // A set in the same cycle as its clear wins, so no event is lost
  assign clear_bits   = wr_status ? bus.wdata[NUM_SOURCES-1:0] : '0;
  assign next_pending = (pending & ~clear_bits) | new_events;

  assign unmasked     = pending[NUM_MASKABLE-1:0] & pending_mask[NUM_MASKABLE-1:0];
  assign winner       = pick_winner(unmasked);
  assign any_unmasked = |(pending & pending_mask[NUM_SOURCES-1:0]);

  // Blanking request ignores the mask flag; maskable ones need it clear
  assign take_nmi = cpu_ack && nmi_pending;
  assign take_irq = cpu_ack && !nmi_pending && !cpu_mask_flag
                    && (winner != 3'h7);

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  // Unmapped offsets read as zero
  always_comb begin
    rd_mux = '0;
    case (bus.addr)
      OFS_DISPLAY_CONTROL_ONE: rd_mux = display_control_one;
      OFS_PIN_EDGE_CONTROL:    rd_mux = pin_edge_control;
      OFS_PENDING_STATUS:      rd_mux = {1'b0, pending};
      OFS_PENDING_MASK:        rd_mux = pending_mask;
      OFS_SERVICE_STATE:       rd_mux = {nmi_pending, 1'b0, state, served};
      OFS_VECTOR_LOW:          rd_mux = vector_addr[7:0];
      default:                 rd_mux = '0;
    endcase
  end

  // ----------------------------------------------------------------
  // Service state machine
  // ----------------------------------------------------------------
  // A vector stays presented until the core signals it is done
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (take_nmi) begin
          next_state = ST_NMI;
        end else if (take_irq) begin
          next_state = ST_IRQ;
        end
      end
      ST_NMI: begin
        if (cpu_done) begin
          next_state = ST_IDLE;
        end
      end
      ST_IRQ: begin
        if (cpu_done) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;                          // Recover from illegal code
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Software writes land directly; no side effects beyond storage
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      display_control_one <= RST_DISPLAY_CONTROL_ONE;
      pin_edge_control    <= RST_PIN_EDGE_CONTROL;
      pending_mask        <= RST_PENDING_MASK;
    end else begin
      if (wr_display) begin
        display_control_one <= bus.wdata;
      end
      if (wr_pin_edge) begin
        pin_edge_control <= bus.wdata;
      end
      if (wr_mask) begin
        pending_mask <= bus.wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pending flags
  // ----------------------------------------------------------------
  // Maskable flags are cleared only by software, so the handler must
  // clear its own source or the same vector is taken again at return
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pending <= RST_PENDING;
    end else begin
      pending <= next_pending;
    end
  end

  // ----------------------------------------------------------------
  // Blanking request
  // ----------------------------------------------------------------
  // Edge-like: consumed by acceptance, a new blanking sets it again
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      nmi_pending <= 1'b0;
    end else if (new_events[SRC_BLANK]) begin
      nmi_pending <= 1'b1;
    end else if (take_nmi && state == ST_IDLE) begin
      nmi_pending <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Vector latch and state
  // ----------------------------------------------------------------
  // The vector is frozen at acceptance so later arrivals cannot change
  // the address the core is fetching from
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state        <= ST_IDLE;
      served       <= 3'h7;
      vector_addr  <= '0;
      vector_valid <= 1'b0;
    end else begin
      state <= next_state;
      if (state == ST_IDLE && take_nmi) begin
        served       <= 3'(SRC_BLANK);
        vector_addr  <= vector_of(3'(SRC_BLANK));
        vector_valid <= 1'b1;
      end else if (state == ST_IDLE && take_irq) begin
        served       <= winner;
        vector_addr  <= vector_of(winner);
        vector_valid <= 1'b1;
      end else if (state != ST_IDLE && cpu_done) begin
        served       <= 3'h7;
        vector_valid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Request outputs and read data
  // ----------------------------------------------------------------
  // Request lines are registered, so a flag shows one cycle after it sets
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cpu_irq   <= 1'b0;
      cpu_nmi   <= 1'b0;
      irq_out   <= 1'b0;
      reg_rdata <= '0;
    end else begin
      cpu_irq   <= (|unmasked) && !cpu_mask_flag;
      cpu_nmi   <= nmi_pending;
      irq_out   <= any_unmasked;
      reg_rdata <= bus.rd ? rd_mux : '0;
    end
  end

endmodule : mci_ctrl

// ### rtl/mci_pin_edge.sv
// Synchroniser and falling edge detector for the port G bit zero pin
`timescale 1ns/1ps
module mci_pin_edge (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic pin,
  output logic      fall
);
  import mci_pkg::*;

  logic sync_a;                                        // First stage, read only by sync_b
  logic sync_b;                                        // Second stage, safe to use
  logic last_b;                                        // Previous safe level

  // ----------------------------------------------------------------
  // Two stage synchroniser then edge register
  // ----------------------------------------------------------------
  // Reset to high so a pin held low at release is seen as a falling edge
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sync_a <= 1'b1;
      sync_b <= 1'b1;
      last_b <= 1'b1;
      fall   <= 1'b0;
    end else begin
      sync_a <= pin;
      sync_b <= sync_a;
      last_b <= sync_b;
      fall   <= last_b & ~sync_b;
    end
  end

endmodule : mci_pin_edge

// ### rtl/mci_pkg.sv
// Package of constants and types for the main processor interrupt controller
package mci_pkg;

  // ----------------------------------------------------------------
  // Register bus shape
  // ----------------------------------------------------------------
  localparam int ADDR_W = 4;                           // Register address width
  localparam int DATA_W = 8;                           // Register data width

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_DISPLAY_CONTROL_ONE = 4'h0;  // Blanking request enable
  localparam logic [ADDR_W-1:0] OFS_PIN_EDGE_CONTROL    = 4'h1;  // Pin edge request enable
  localparam logic [ADDR_W-1:0] OFS_PENDING_STATUS      = 4'h2;  // Sticky pending flags, write one to clear
  localparam logic [ADDR_W-1:0] OFS_PENDING_MASK        = 4'h3;  // Enables for the interrupt line
  localparam logic [ADDR_W-1:0] OFS_SERVICE_STATE      = 4'h4;  // Served source and service state
  localparam logic [ADDR_W-1:0] OFS_VECTOR_LOW          = 4'h5;  // Low byte of last vector

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_BLANK_EN    = 0;                  // In display control one
  localparam int BIT_PIN_EDGE_EN = 0;                  // In pin edge control
  localparam int NUM_MASKABLE    = 6;                  // Maskable request lines
  localparam int NUM_SOURCES     = 7;                  // Maskable plus blanking request
  localparam int SRC_PIN         = 0;                  // Pin falling edge
  localparam int SRC_PERIODIC    = 1;                  // Periodic counter
  localparam int SRC_SOUND       = 2;                  // Sound processor
  localparam int SRC_SERIAL      = 3;                  // Serial port
  localparam int SRC_SYNC_SERIAL = 4;                  // Synchronous serial port
  localparam int SRC_CLOCK_POS   = 5;                  // Clock or display position
  localparam int SRC_BLANK       = 6;                  // Vertical blanking request

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] RST_DISPLAY_CONTROL_ONE = 8'h00;  // Blanking request off
  localparam logic [DATA_W-1:0] RST_PIN_EDGE_CONTROL    = 8'h00;  // Pin detection off
  localparam logic [DATA_W-1:0] RST_PENDING_MASK        = 8'h00;  // Line fully masked
  localparam logic [NUM_SOURCES-1:0] RST_PENDING        = 7'h00;  // Nothing pending

  // ----------------------------------------------------------------
  // Vector addresses, upper byte always zero
  // ----------------------------------------------------------------
  localparam logic [23:0] VEC_BLANK       = 24'h00fffa;  // Non-maskable
  localparam logic [23:0] VEC_PIN         = 24'h00fffe;  // Pin edge
  localparam logic [23:0] VEC_PERIODIC    = 24'h00fff8;  // Periodic counter
  localparam logic [23:0] VEC_SOUND       = 24'h00fff6;  // Sound processor
  localparam logic [23:0] VEC_SERIAL      = 24'h00fff4;  // Serial port
  localparam logic [23:0] VEC_SYNC_SERIAL = 24'h00fff2;  // Synchronous serial
  localparam logic [23:0] VEC_CLOCK_POS   = 24'h00fff0;  // Clock or position
  localparam logic [7:0]  BANK_ZERO       = 8'h00;       // Forced upper address byte

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;                           // Register address
    logic [DATA_W-1:0] wdata;                          // Write data
    logic              wr;                             // Write strobe
    logic              rd;                             // Read strobe
  } mci_bus_req_t;

  typedef struct packed {
    logic clock_pos;                                   // Real-time clock or position pulse
    logic sync_serial;                                 // Synchronous serial pulse
    logic serial;                                      // Serial port pulse
    logic sound;                                       // Sound processor pulse
    logic periodic;                                    // Periodic counter pulse
  } mci_events_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,                                 // No vector presented
    ST_NMI   = 3'b010,                                 // Blanking vector presented
    ST_IRQ   = 3'b100                                  // Maskable vector presented
  } mci_state_t;

endpackage : mci_pkg

// ### tb/mci_cpu_model.sv
// Behavioural processor core that takes interrupts and fetches vectors
`timescale 1ns/1ps
module mci_cpu_model (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        go,
  input  wire logic [3:0]  lag,
  input  wire logic        cpu_mask_flag,
  input  wire logic        cpu_irq,
  input  wire logic        cpu_nmi,
  input  wire logic [23:0] vector_addr,
  input  wire logic        vector_valid,
  output logic             cpu_ack,
  output logic             cpu_done,
  output logic [23:0]      last_vec,
  output int               served
);
  logic [2:0] st;   // Service step
  logic [3:0] cnt;  // Fetch delay, lag makes the core slow or prompt
  // ------------------------------------------------------------
  // Take, fetch, finish; waits for go low so one go gives one service
  // ------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= 3'd0;
      cnt <= 4'h0;
      cpu_ack <= 1'b0;
      cpu_done <= 1'b0;
      last_vec <= 24'h000000;
      served <= 0;
    end else begin
      cpu_ack <= 1'b0;
      cpu_done <= 1'b0;
      case (st)
        3'd0: if (go && !vector_valid && (cpu_nmi || (cpu_irq && !cpu_mask_flag))) begin
          cpu_ack <= 1'b1;
          st <= 3'd1;
        end
        3'd1: if (vector_valid) begin
          last_vec <= vector_addr;
          cnt <= lag;
          st <= 3'd2;
        end
        3'd2: if (cnt == 4'h0) begin
          cpu_done <= 1'b1;
          st <= 3'd3;
        end else cnt <= cnt - 4'h1;
        3'd3: if (!vector_valid) begin
          served <= served + 1;
          st <= 3'd4;
        end
        default: if (!go) st <= 3'd0;
      endcase
    end
  end
endmodule : mci_cpu_model

// ### tb/mci_ctrl_assertions.sv
// Port checker for the main processor interrupt controller
`timescale 1ns/1ps
module mci_ctrl_assertions
  import mci_pkg::*;
(
  input wire logic                         clk,
  input wire logic                         sys_rst,
  input wire mci_pkg::mci_bus_req_t        bus,
  input wire logic [mci_pkg::DATA_W-1:0]   reg_rdata,
  input wire logic                         cpu_mask_flag,
  input wire logic                         cpu_ack,
  input wire logic                         cpu_done,
  input wire logic                         cpu_irq,
  input wire logic                         cpu_nmi,
  input wire logic [23:0]                  vector_addr,
  input wire logic                         vector_valid,
  input wire logic                         irq_out
);
  // ------------------------------------------------------------
  // One clock domain; reset silences every check
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_bank; vector_valid |-> vector_addr[23:16] == BANK_ZERO; endproperty
  a_bank: assert property (p_bank) else $error("vector upper byte not zero");
  property p_vec_set;
    vector_valid |-> vector_addr inside {24'h00fffa, 24'h00fffe, 24'h00fff8, 24'h00fff6, 24'h00fff4,
                                         24'h00fff2, 24'h00fff0};
  endproperty
  a_vec_set: assert property (p_vec_set) else $error("vector outside table");
  // Blanking request wins the acceptance even with the flag set
  property p_nmi_vec; cpu_ack && cpu_nmi && !vector_valid |=> vector_valid && vector_addr == 24'h00fffa; endproperty
  a_nmi_vec: assert property (p_nmi_vec) else $error("blanking vector not presented");
  property p_hold_vec; vector_valid && !cpu_done |=> vector_valid && $stable(vector_addr); endproperty
  a_hold_vec: assert property (p_hold_vec) else $error("vector dropped before fetch done");
  property p_release; vector_valid && cpu_done |=> !vector_valid; endproperty
  a_release: assert property (p_release) else $error("vector still valid after done");
  property p_cause; $rose(vector_valid) |-> $past(cpu_ack); endproperty
  a_cause: assert property (p_cause) else $error("vector without acceptance");
  property p_flag; cpu_mask_flag [*2] |-> !cpu_irq; endproperty
  a_flag: assert property (p_flag) else $error("maskable request with flag set");
  property p_line; cpu_irq |-> irq_out; endproperty
  a_line: assert property (p_line) else $error("processor request without line");
  // Line may only fall after a write or an acceptance two edges back
  property p_sticky;
    irq_out && !bus.wr && !$past(bus.wr) && !cpu_ack && !$past(cpu_ack) |=> irq_out;
  endproperty
  a_sticky: assert property (p_sticky) else $error("pending flag lost");
  property p_rdata; !bus.rd |=> reg_rdata == 8'h00; endproperty
  a_rdata: assert property (p_rdata) else $error("read data outside answer cycle");
endmodule : mci_ctrl_assertions

bind mci_ctrl mci_ctrl_assertions u_chk (.clk(clk), .sys_rst(sys_rst), .bus(bus), .reg_rdata(reg_rdata),
  .cpu_mask_flag(cpu_mask_flag), .cpu_ack(cpu_ack), .cpu_done(cpu_done), .cpu_irq(cpu_irq),
  .cpu_nmi(cpu_nmi), .vector_addr(vector_addr), .vector_valid(vector_valid), .irq_out(irq_out));

// ### tb/tb_top.sv
// Self-checking testbench for the main processor interrupt controller
`timescale 1ns/1ps
module tb_top;
  import mci_pkg::*;
  logic         clk = 1'b0;
  logic         sys_rst = 1'b1;
  mci_bus_req_t bus = '0;
  mci_events_t  ev = '0;
  logic         vbl = 1'b0, pin = 1'b1, pin_in = 1'b1, flag = 1'b0, go = 1'b0;
  logic [3:0]   lag = 4'h0;
  logic [7:0]   rdata;
  logic         cpu_ack, cpu_done, cpu_irq, cpu_nmi, vvalid, irq_out;
  logic [23:0]  vaddr, last_vec;
  logic [5:0]   want;
  int           served, idx, error_cnt = 0, checks_done = 0;
  // Maskable vectors in priority order, pin first
  logic [23:0]  vtab [6] = '{24'h00fffe, 24'h00fff8, 24'h00fff6, 24'h00fff4, 24'h00fff2, 24'h00fff0};

  always #20 clk = ~clk;

  mci_ctrl DUT (.clk(clk), .sys_rst(sys_rst), .bus(bus), .reg_rdata(rdata), .events(ev), .vblank_start(vbl),
    .port_g_bit_zero(pin), .port_g_bit_zero_is_input(pin_in), .cpu_mask_flag(flag), .cpu_ack(cpu_ack),
    .cpu_done(cpu_done), .cpu_irq(cpu_irq), .cpu_nmi(cpu_nmi), .vector_addr(vaddr), .vector_valid(vvalid),
    .irq_out(irq_out));
  mci_cpu_model u_cpu (.clk(clk), .sys_rst(sys_rst), .go(go), .lag(lag), .cpu_mask_flag(flag),
    .cpu_irq(cpu_irq), .cpu_nmi(cpu_nmi), .vector_addr(vaddr), .vector_valid(vvalid), .cpu_ack(cpu_ack),
    .cpu_done(cpu_done), .last_vec(last_vec), .served(served));

  // ------------------------------------------------------------
  // Verdict, comparison and bus tasks
  // ------------------------------------------------------------
  task automatic close_out;
    if (error_cnt == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk) bus.wr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(posedge clk) bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk) bus.rd <= 1'b0;
    #1 chk(what, {16'h0000, exp}, {16'h0000, rdata});
  endtask : rd
  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
  endtask : cycles
  // One-cycle source pulses; bit 0 drops the pin for seven cycles
  task automatic pulse(input logic [5:0] e, input logic v);
    @(posedge clk) ev <= mci_events_t'(e[5:1]);
    vbl <= v;
    pin <= ~e[0];
    @(posedge clk) ev <= '0;
    vbl <= 1'b0;
    cycles(6);
    pin <= 1'b1;
  endtask : pulse
  // Let the core take one interrupt; the wait is bounded
  task automatic take(input logic [23:0] exp, input string what);
    int n0;
    n0 = served;
    @(posedge clk) go <= 1'b1;
    lag <= 4'($urandom_range(9, 0));
    for (int i = 0; i < 80 && served == n0; i++) @(posedge clk);
    go <= 1'b0;
    if (served == n0) begin
      error_cnt++;
      $display("mismatch %s expected %0d seen %0d", what, n0 + 1, served);
      close_out();
    end else chk(what, exp, last_vec);
  endtask : take
  function automatic int first_set(input logic [5:0] b);
    for (int i = 0; i < 6; i++) if (b[i]) return i;
    return 0;
  endfunction : first_set

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    void'($urandom(14161));
    cycles(10);
    sys_rst <= 1'b0;
    for (int a = 0; a < 6; a++) rd(4'(a), (a == 4) ? 8'h0f : 8'h00, "reset value");
    wr(4'hf, 8'hff);
    rd(4'hf, 8'h00, "unmapped");
    wr(OFS_PENDING_MASK, 8'h3f);
    pulse(6'h01, 1'b0);
    rd(OFS_PENDING_STATUS, 8'h00, "pin disabled");
    wr(OFS_PIN_EDGE_CONTROL, 8'h01);
    pin_in <= 1'b0;
    pulse(6'h01, 1'b0);
    rd(OFS_PENDING_STATUS, 8'h00, "pin as output");
    pin_in <= 1'b1;
    pulse(6'h01, 1'b0);
    rd(OFS_PENDING_STATUS, 8'h01, "pin armed");
    wr(OFS_PENDING_STATUS, 8'h01);
    // All six together first, then random mixes, drained by priority
    for (int k = 0; k < 16; k++) begin
      want = (k == 0) ? 6'h3f : 6'($urandom_range(63, 1));
      pulse(want, 1'b0);
      rd(OFS_PENDING_STATUS, {2'b00, want}, "pending flags");
      while (want != 6'h00) begin
        idx = first_set(want);
        take(vtab[idx], "maskable vector");
        want[idx] = 1'b0;
        wr(OFS_PENDING_STATUS, 8'h01 << idx);
      end
    end
    flag <= 1'b1;
    pulse(6'h00, 1'b1);
    rd(OFS_PENDING_STATUS, 8'h00, "blanking disabled");
    wr(OFS_DISPLAY_CONTROL_ONE, 8'h01);
    pulse(6'h02, 1'b1);
    rd(OFS_PENDING_STATUS, 8'h42, "blanking pending");
    chk("blanking line", 24'h1, {23'h0, cpu_nmi});
    take(24'h00fffa, "blanking vector");
    #1 chk("irq under flag", 24'h0, {23'h0, cpu_irq});
    flag <= 1'b0;
    take(24'h00fff8, "after flag clear");
    wr(OFS_PENDING_STATUS, 8'h42);
    wr(OFS_PENDING_MASK, 8'h00);
    pulse(6'h04, 1'b0);
    #1 chk("masked line", 24'h0, {23'h0, irq_out});
    wr(OFS_PENDING_MASK, 8'h04);
    cycles(2);
    #1 chk("unmasked line", 24'h1, {23'h0, irq_out});
    wr(OFS_PENDING_STATUS, 8'h04);
    cycles(2);
    #1 chk("cleared line", 24'h0, {23'h0, irq_out});
    close_out();
  end
endmodule : tb_top
